//--- rtl/pnfc_codec.sv
// numeric format codec: packs and unpacks command data words
`timescale 1ns/100ps
module pnfc_codec #(
  parameter int VAL_W   = 32,
  parameter int SCALE_W = 16
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     nrst,
  // decode side: word from the command handler
  input  wire logic                     dec_valid,
  input  wire pnfc_pkg::pnfc_fmt_e      dec_fmt,
  input  wire logic                     dec_byte_wide,
  input  wire logic                     dec_signed,
  input  wire logic [SCALE_W-1:0]       dec_scale,
  input  wire logic [15:0]              dec_word,
  output logic                          dec_out_valid,
  output logic signed [VAL_W-1:0]       dec_mant,
  output logic signed [4:0]             dec_exp,
  output logic [7:0]                    dec_char,
  // encode side: internal value to a command word
  input  wire logic                     enc_valid,
  input  wire pnfc_pkg::pnfc_fmt_e      enc_fmt,
  input  wire logic                     enc_byte_wide,
  input  wire logic signed [VAL_W-1:0]  enc_value,
  input  wire logic signed [4:0]        enc_exp,
  output logic                          enc_out_valid,
  output logic [15:0]                   enc_word
);

  // ************************************************************
  // decode path
  // ************************************************************
  logic                      dec_valid_q;
  logic signed [VAL_W-1:0]   dec_mant_q;
  logic signed [4:0]         dec_exp_q;
  logic [7:0]                dec_char_q;
  logic signed [VAL_W-1:0]   dec_mant_d;
  logic signed [4:0]         dec_exp_d;
  logic signed [SCALE_W:0]   scale_s;
  logic signed [VAL_W-1:0]   raw_s;

  always_comb begin
    scale_s    = $signed({1'b0, dec_scale});
    raw_s      = dec_signed ? VAL_W'($signed(dec_word)) : VAL_W'({16'h0000, dec_word});
    dec_mant_d = '0;
    dec_exp_d  = 5'sh00;
    case (dec_fmt)
      pnfc_pkg::FMT_LINEAR_EXP5_MANT11: begin
        dec_exp_d  = $signed(dec_word[pnfc_pkg::EXP_MSB:pnfc_pkg::EXP_LSB]);
        dec_mant_d = VAL_W'($signed(dec_word[pnfc_pkg::MANT_MSB:0]));
      end
      pnfc_pkg::FMT_LINEAR_UNSIGNED16_FIXED: begin
        dec_mant_d = VAL_W'({16'h0000, dec_word});
        dec_exp_d  = $signed(pnfc_pkg::FIXED_EXP16);
      end
      pnfc_pkg::FMT_REGISTER_FIELD: begin
        dec_mant_d = dec_byte_wide ? VAL_W'({24'h000000, dec_word[7:0]})
                                   : VAL_W'({16'h0000, dec_word});
      end
      pnfc_pkg::FMT_UNSIGNED_INTEGER_WORD: begin
        dec_mant_d = VAL_W'({16'h0000, dec_word});
      end
      pnfc_pkg::FMT_CUSTOM_SCALED: begin
        dec_mant_d = VAL_W'(raw_s * scale_s);
      end
      default: begin
        dec_mant_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      dec_valid_q <= 1'b0;
      dec_mant_q  <= '0;
      dec_exp_q   <= 5'sh00;
      dec_char_q  <= 8'h00;
    end else begin
      dec_valid_q <= dec_valid;
      if (dec_valid) begin
        dec_mant_q <= dec_mant_d;
        dec_exp_q  <= dec_exp_d;
        // text: one Latin-1 byte per beat, low byte of the word
        if (dec_fmt == pnfc_pkg::FMT_TEXT_STRING) begin
          dec_char_q <= dec_word[7:0];
        end
      end
    end
  end

  assign dec_out_valid = dec_valid_q;
  assign dec_mant      = dec_mant_q;
  assign dec_exp       = dec_exp_q;
  assign dec_char      = dec_char_q;

  // ************************************************************
  // encode path
  // ************************************************************
  logic                      enc_valid_q;
  logic [15:0]               enc_word_q;
  logic [15:0]               enc_word_d;
  logic signed [VAL_W-1:0]   norm_m;
  logic signed [6:0]         norm_e;
  logic signed [VAL_W-1:0]   fix_m;
  logic signed [4:0]         fix_e;

  // shift right until the mantissa fits, else left for precision;
  // truncates toward minus infinity when shifting right
  always_comb begin
    norm_m = enc_value;
    norm_e = 7'(enc_exp);
    for (int i = 0; i < VAL_W; i++) begin
      if ((norm_m > VAL_W'(pnfc_pkg::MANT_MAX) || norm_m < VAL_W'(pnfc_pkg::MANT_MIN))
          && norm_e < 7'sd15) begin
        norm_m = norm_m >>> 1;
        norm_e = norm_e + 7'sd1;
      // double only from inside the range: a huge value held at the top exponent would wrap
      end else if (norm_m != '0 && norm_m <= VAL_W'(pnfc_pkg::MANT_MAX)
                   && norm_m >= VAL_W'(pnfc_pkg::MANT_MIN)
                   && (norm_m <<< 1) <= VAL_W'(pnfc_pkg::MANT_MAX)
                   && (norm_m <<< 1) >= VAL_W'(pnfc_pkg::MANT_MIN) && norm_e > -7'sd16) begin
        norm_m = norm_m <<< 1;
        norm_e = norm_e - 7'sd1;
      end
    end
    // saturate if the exponent ran out of range
    fix_e = norm_e[4:0];
    fix_m = norm_m;
    if (norm_m > VAL_W'(pnfc_pkg::MANT_MAX)) begin
      fix_m = VAL_W'(pnfc_pkg::MANT_MAX);
    end else if (norm_m < VAL_W'(pnfc_pkg::MANT_MIN)) begin
      fix_m = VAL_W'(pnfc_pkg::MANT_MIN);
    end
  end

  always_comb begin
    case (enc_fmt)
      pnfc_pkg::FMT_LINEAR_EXP5_MANT11: begin
        enc_word_d = {fix_e, fix_m[10:0]};
      end
      pnfc_pkg::FMT_REGISTER_FIELD: begin
        enc_word_d = enc_byte_wide ? {8'h00, enc_value[7:0]} : enc_value[15:0];
      end
      pnfc_pkg::FMT_TEXT_STRING: begin
        enc_word_d = {8'h00, enc_value[7:0]};
      end
      // unsigned linear value arrives pre-scaled by 2^-12; no exponent travels
      default: begin
        enc_word_d = enc_value[15:0];
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      enc_valid_q <= 1'b0;
      enc_word_q  <= pnfc_pkg::WORD_RESET;
    end else begin
      enc_valid_q <= enc_valid;
      if (enc_valid) begin
        enc_word_q <= enc_word_d;
      end
    end
  end

  assign enc_out_valid = enc_valid_q;
  assign enc_word      = enc_word_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_l11_in;
    dec_valid && dec_fmt == pnfc_pkg::FMT_LINEAR_EXP5_MANT11;
  endsequence

  a_dec_exp_field: assert property (@(posedge clock) disable iff (!nrst)
    s_l11_in |=> dec_exp == $signed($past(dec_word[15:11])))
    else $error("linear exponent not taken from top five bits");

  a_dec_mant_sext: assert property (@(posedge clock) disable iff (!nrst)
    s_l11_in |=> dec_mant == VAL_W'($signed($past(dec_word[10:0]))))
    else $error("linear mantissa not sign extended");

  a_dec_l16_mant: assert property (@(posedge clock) disable iff (!nrst)
    dec_valid && dec_fmt == pnfc_pkg::FMT_LINEAR_UNSIGNED16_FIXED
    |=> dec_mant == VAL_W'({16'h0000, $past(dec_word)}))
    else $error("unsigned linear mantissa wrong");

  a_dec_l16_exp: assert property (@(posedge clock) disable iff (!nrst)
    dec_valid && dec_fmt == pnfc_pkg::FMT_LINEAR_UNSIGNED16_FIXED |=> dec_exp == -5'sd12)
    else $error("unsigned linear exponent not minus twelve");

  a_dec_reg_byte: assert property (@(posedge clock) disable iff (!nrst)
    dec_valid && dec_fmt == pnfc_pkg::FMT_REGISTER_FIELD && dec_byte_wide
    |=> dec_mant[VAL_W-1:8] == '0)
    else $error("byte register field leaks upper bits");

  a_dec_int_word: assert property (@(posedge clock) disable iff (!nrst)
    dec_valid && dec_fmt == pnfc_pkg::FMT_UNSIGNED_INTEGER_WORD
    |=> dec_mant == VAL_W'({16'h0000, $past(dec_word)}) && dec_out_valid)
    else $error("integer word altered");

  a_dec_custom: assert property (@(posedge clock) disable iff (!nrst)
    dec_valid && dec_fmt == pnfc_pkg::FMT_CUSTOM_SCALED && !dec_signed && dec_scale == 16'h0001
    |=> dec_mant == VAL_W'({16'h0000, $past(dec_word)}))
    else $error("custom format unit scale wrong");

  a_dec_text: assert property (@(posedge clock) disable iff (!nrst)
    dec_valid && dec_fmt == pnfc_pkg::FMT_TEXT_STRING |=> dec_char == $past(dec_word[7:0]))
    else $error("text byte not carried");

  a_enc_l11_range: assert property (@(posedge clock) disable iff (!nrst)
    enc_valid && enc_fmt == pnfc_pkg::FMT_LINEAR_EXP5_MANT11 && enc_value == VAL_W'(4096)
    && enc_exp == 5'sh00 ##1 enc_out_valid |-> enc_word == 16'h1A00)
    else $error("encoder exponent choice wrong");

endmodule : pnfc_codec

//--- shared/pnfc_pkg.sv
// shared constants for the numeric format codec
package pnfc_pkg;

  // ************************************************************
  // format selection
  // ************************************************************
  typedef enum logic [2:0] {
    FMT_LINEAR_EXP5_MANT11       = 3'h0,
    FMT_LINEAR_UNSIGNED16_FIXED  = 3'h1,
    FMT_REGISTER_FIELD           = 3'h2,
    FMT_UNSIGNED_INTEGER_WORD    = 3'h3,
    FMT_CUSTOM_SCALED            = 3'h4,
    FMT_TEXT_STRING              = 3'h5
  } pnfc_fmt_e;

  // ************************************************************
  // field layout and fixed values
  // ************************************************************
  localparam int          EXP_MSB       = 15;
  localparam int          EXP_LSB       = 11;
  localparam int          MANT_MSB      = 10;
  localparam logic [4:0]  FIXED_EXP16   = 5'h14;   // minus twelve
  localparam logic signed [10:0] MANT_MAX = 11'sh3FF;
  localparam logic signed [10:0] MANT_MIN = -11'sh400;
  localparam logic [4:0]  EXP_MAX       = 5'h0F;   // plus fifteen
  localparam logic [4:0]  EXP_MIN       = 5'h10;   // minus sixteen
  localparam logic [15:0] WORD_RESET    = 16'h0000;

endpackage : pnfc_pkg

//--- verification/pnfc_cmd_model.sv
// command handler model that issues data words and values to the codec
`timescale 1ns/100ps
module pnfc_cmd_model (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           nrst,
  // requests from the bench
  input  wire logic           req_dec,
  input  wire logic           req_enc,
  input  wire logic [2:0]     fmt,
  input  wire logic           bw,
  input  wire logic           sg,
  input  wire logic [15:0]    scale,
  input  wire logic [15:0]    word,
  input  wire logic [31:0]    value,
  input  wire logic [4:0]     eexp,
  // towards the codec
  output logic                dec_valid,
  output pnfc_pkg::pnfc_fmt_e dec_fmt,
  output logic                byte_wide,
  output logic                dec_signed,
  output logic [15:0]         dec_scale,
  output logic [15:0]         dec_word,
  output logic                enc_valid,
  output pnfc_pkg::pnfc_fmt_e enc_fmt,
  output logic signed [31:0]  enc_value,
  output logic signed [4:0]   enc_exp
);
  initial begin
    {dec_valid, enc_valid, byte_wide, dec_signed} = 4'h0;
    {dec_scale, dec_word, enc_value, enc_exp} = '0;
    dec_fmt = pnfc_pkg::FMT_LINEAR_EXP5_MANT11;
    enc_fmt = pnfc_pkg::FMT_LINEAR_EXP5_MANT11;
  end
  always @(posedge clock) begin
    dec_valid <= nrst & req_dec;
    enc_valid <= nrst & req_enc;
    dec_fmt <= pnfc_pkg::pnfc_fmt_e'(fmt);
    enc_fmt <= pnfc_pkg::pnfc_fmt_e'(fmt);
    byte_wide <= bw;
    dec_signed <= sg;
    dec_scale <= scale;
    enc_value <= value;
    enc_exp <= eexp;
    // a released word flips so stale data never looks valid
    dec_word <= req_dec ? word : ~dec_word;
  end
endmodule : pnfc_cmd_model

//--- verification/tb.sv
// self-checking bench for the numeric format codec
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [2:0]  fmt;
    logic        bw;
    logic        sg;
    logic        een;
    logic [15:0] scale;
    logic [15:0] word;
    logic [31:0] mant;
    logic [4:0]  ex;
    logic [31:0] value;
    logic [4:0]  eexp;
    logic [15:0] eword;
  } row_s;
  row_s rows [14] = '{
    '{0, 0, 0, 1, 0, 16'h9807, 7, 5'h13, 4096, 0, 16'h1A00},
    '{0, 0, 0, 1, 0, 16'h0400, -1024, 0, 3, 0, 16'hC300},
    '{0, 0, 0, 1, 0, 16'h03FF, 1023, 0, -1, 0, 16'hB400},
    '{0, 0, 0, 1, 0, 16'h8001, 1, 5'h10, 3, 2, 16'hD300},
    '{1, 0, 0, 1, 0, 16'h9800, 38912, 5'h14, 38912, 0, 16'h9800},
    '{2, 1, 0, 1, 0, 16'hABCD, 16'h00CD, 0, 16'h0012, 0, 16'h0012},
    '{2, 0, 0, 1, 0, 16'hABCD, 16'hABCD, 0, 16'h1234, 0, 16'h1234},
    '{3, 0, 0, 1, 0, 16'h9807, 38919, 0, 38919, 0, 16'h9807},
    '{4, 0, 0, 1, 3, 16'h0010, 48, 0, 16'h0F3C, 0, 16'h0F3C},
    '{4, 0, 1, 1, 5, 16'hFFFE, -10, 0, -10, 0, 16'hFFF6},
    '{5, 0, 0, 1, 0, 16'h0041, 16'h0041, 0, 32'h1241, 0, 16'h0041},
    '{6, 0, 0, 0, 0, 16'h1234, 0, 0, 0, 0, 0},
    '{4, 0, 0, 0, 1, 16'h8001, 32769, 0, 0, 0, 0},
    '{0, 0, 0, 1, 0, 16'h7BFF, 1023, 5'h0F, 32'h7FFFFFFF, 5'h0F, 16'h7BFF}};
  logic clock, nrst, rq_d, rq_e, dec_valid, byte_wide, dec_signed, enc_valid;
  logic dec_out_valid, enc_out_valid;
  pnfc_pkg::pnfc_fmt_e dec_fmt, enc_fmt;
  logic [15:0] dec_scale, dec_word, enc_word;
  logic signed [31:0] enc_value, dec_mant;
  logic signed [4:0] enc_exp, dec_exp;
  logic [7:0] dec_char;
  row_s cur;
  int fails, checked;
  // ************************************************************
  // instances
  // ************************************************************
  pnfc_cmd_model i_pnfc_cmd_model (.clock(clock), .nrst(nrst), .req_dec(rq_d),
    .req_enc(rq_e), .fmt(cur.fmt), .bw(cur.bw), .sg(cur.sg), .scale(cur.scale),
    .word(cur.word), .value(cur.value), .eexp(cur.eexp), .dec_valid(dec_valid),
    .dec_fmt(dec_fmt), .byte_wide(byte_wide), .dec_signed(dec_signed),
    .dec_scale(dec_scale), .dec_word(dec_word), .enc_valid(enc_valid),
    .enc_fmt(enc_fmt), .enc_value(enc_value), .enc_exp(enc_exp));
  pnfc_codec i_pnfc_codec (.clock(clock), .nrst(nrst), .dec_valid(dec_valid),
    .dec_fmt(dec_fmt), .dec_byte_wide(byte_wide), .dec_signed(dec_signed),
    .dec_scale(dec_scale), .dec_word(dec_word), .dec_out_valid(dec_out_valid),
    .dec_mant(dec_mant), .dec_exp(dec_exp), .dec_char(dec_char),
    .enc_valid(enc_valid), .enc_fmt(enc_fmt), .enc_byte_wide(byte_wide),
    .enc_value(enc_value), .enc_exp(enc_exp), .enc_out_valid(enc_out_valid),
    .enc_word(enc_word));
  always #5 clock = ~clock;
  // ************************************************************
  // tasks
  // ************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask : chk
  task apply(input row_s r);
    @(posedge clock);
    cur <= r;
    rq_d <= 1'b1;
    rq_e <= r.een;
  endtask : apply
  task final_report;
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    #20000;
    fails++;
    final_report();
  end
  initial begin
    {clock, nrst, rq_d, rq_e} = 4'h0;
    cur = '0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    #1 chk(enc_word, 0);
    foreach (rows[i]) begin
      apply(rows[i]);
      @(posedge clock);
      rq_d <= 1'b0;
      rq_e <= 1'b0;
      @(posedge clock);
      #1 chk(dec_out_valid, 1);
      if (rows[i].fmt == 3'h5) chk(dec_char, rows[i].mant[7:0]);
      else chk(dec_mant, rows[i].mant);
      chk($unsigned(dec_exp), rows[i].ex);
      if (rows[i].een) chk(enc_word, rows[i].eword);
    end
    @(posedge clock);
    #1 chk(enc_word, rows[13].eword);
    chk(enc_out_valid, 0);
    apply(rows[0]);
    apply(rows[7]);
    @(posedge clock);
    rq_d <= 1'b0;
    rq_e <= 1'b0;
    #1 chk(dec_mant, 7);
    @(posedge clock);
    #1 chk(dec_mant, 38919);
    chk(enc_word, 16'h9807);
    @(posedge clock);
    #1 chk(dec_out_valid, 0);
    apply(rows[4]);
    @(posedge clock);
    rq_d <= 1'b0;
    rq_e <= 1'b0;
    nrst <= 1'b0;
    @(posedge clock);
    #1 chk(enc_word, 0);
    chk(dec_out_valid, 0);
    nrst <= 1'b1;
    apply(rows[8]);
    @(posedge clock);
    rq_d <= 1'b0;
    rq_e <= 1'b0;
    #1 chk(dec_mant, 0);
    chk(dec_out_valid, 0);
    @(posedge clock);
    #1 chk(dec_mant, rows[8].mant);
    chk(enc_word, rows[8].eword);
    final_report();
  end
endmodule : tb
